// [core/dws_regs.svh]
// register offsets, field positions, reset values and the overview for the waveform sequencer
// Overview of operation
// R1: two converters share one common update pace
// R2: each pace event pops one queued sample
// R3: host samples wait in a fifo queue
// R4: one software command gives exactly one update; the code gives none when the queue is empty
// R5: hardware pace is internal or external signal
// R6: hardware-timed output drains queue per update
// R7: finite mode stops after programmed sample count
// R8: continuous mode runs until stop command
// R9: three continuous data schemes are selectable
// R10: standard regeneration accepts host data while running
// R11: queue-local replay, data writes rejected running
// R12: host keeps local buffer within queue depth
// R13: non-regeneration flags underflow, never repeats samples
// R14: start trigger and pause trigger are supported
// R15: start on chosen trigger edge or software
// R16: active pause level suppresses update events
// R17: internal pace first update after programmable delay
// R18: underflow halts, holds outputs, sets sticky flag
`ifndef DWS_REGS_SVH
`define DWS_REGS_SVH

`define DWS_ADDR_W      8
`define DWS_OFS_CTRL    8'h00
`define DWS_OFS_COUNT   8'h04
`define DWS_OFS_DIV     8'h08
`define DWS_OFS_DELAY   8'h0c
`define DWS_OFS_DATA    8'h10
`define DWS_OFS_CMD     8'h14
`define DWS_OFS_STAT    8'h18
`define DWS_OFS_MASK    8'h1c
`define DWS_OFS_STATE   8'h20
`define DWS_OFS_LEVEL   8'h24
`define DWS_OFS_FILL    8'h28
`define DWS_OFS_DONE    8'h2c

`define DWS_CTRL_W      10
`define DWS_CTRL_RST    10'h000
`define DWS_COUNT_RST   32'h00000010
`define DWS_DIV_RST     32'h00000014
`define DWS_DELAY_RST   32'h00000002

`define DWS_CMD_START   0
`define DWS_CMD_STOP    1
`define DWS_CMD_UPDATE  2
`define DWS_CMD_FLUSH   3

`define DWS_ST_W        4
`define DWS_ST_DONE     0
`define DWS_ST_UNDER    1
`define DWS_ST_REJECT   2
`define DWS_ST_BEGUN    3

`define DWS_TIM_ONDEMAND 2'h0
`define DWS_TIM_FINITE   2'h1
`define DWS_TIM_CONT     2'h2

`define DWS_RGN_STD     2'h0
`define DWS_RGN_LOCAL   2'h1
`define DWS_RGN_NONE    2'h2

`define DWS_PIN_PACE    0
`define DWS_PIN_TBASE   1
`define DWS_PIN_BEGIN   2
`define DWS_PIN_HOLD    3
`define DWS_PIN_N       4

`endif

// [core/dws_pkg.sv]
// types shared by the waveform sequencer
package dws_pkg;

  typedef struct packed {
    logic [15:0] ch1;
    logic [15:0] ch0;
  } dws_sample_t;

  typedef struct packed {
    logic       timebase_ext;
    logic       hold_low;
    logic       hold_en;
    logic       begin_fall;
    logic       begin_en;
    logic       pace_ext;
    logic [1:0] regen;
    logic [1:0] timing;
  } dws_ctrl_t;

  typedef enum logic [1:0] {
    DWS_IDLE,
    DWS_ARMED,
    DWS_DELAY,
    DWS_RUN
  } dws_state_t;

endpackage : dws_pkg

// [core/dws_sequencer.sv]
// two-channel waveform sequencer: register port, sample queue, pacing and triggers
`timescale 1ns/1ps
`include "dws_regs.svh"

module dws_sequencer #(
  parameter int DEPTH = 16
) (
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire logic [`DWS_ADDR_W-1:0] addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [31:0]            rdata,
  input  wire logic                   update_pace_clock,
  input  wire logic                   update_pace_timebase,
  input  wire logic                   generation_begin_trigger,
  input  wire logic                   generation_hold_trigger,
  output logic      [15:0]            converter_ch0,
  output logic      [15:0]            converter_ch1,
  output logic                        update_strobe,
  output logic                        running,
  output logic                        irq
);

  localparam int AW = $clog2(DEPTH);
  localparam int FW = AW + 1;

  // pin synchronisers: three stages, level accepted once stages two and three agree
  logic [`DWS_PIN_N-1:0] pin_in;
  logic [`DWS_PIN_N-1:0] pin_lvl;
  logic [`DWS_PIN_N-1:0] pin_prev;
  assign pin_in = {generation_hold_trigger, generation_begin_trigger, update_pace_timebase, update_pace_clock};

  generate
    for (genvar gi = 0; gi < `DWS_PIN_N; gi++)
    begin : g_sync
      logic [2:0] stage;
      always_ff @(posedge sys_clk)
      begin
        if (!nrst)
        begin
          stage        <= 3'h0;
          pin_lvl[gi]  <= 1'b0;
          pin_prev[gi] <= 1'b0;
        end
        else
        begin
          stage        <= {stage[1:0], pin_in[gi]};
          pin_lvl[gi]  <= (stage[1] == stage[2]) ? stage[1] : pin_lvl[gi];
          pin_prev[gi] <= pin_lvl[gi];
        end
      end
    end
  endgenerate

  logic [`DWS_PIN_N-1:0] pin_rise;
  logic [`DWS_PIN_N-1:0] pin_fall;
  assign pin_rise = pin_lvl & ~pin_prev;
  assign pin_fall = ~pin_lvl & pin_prev;

  // state
  dws_pkg::dws_ctrl_t         ctrl,      next_ctrl;
  logic [31:0]                count_cfg, next_count_cfg;
  logic [31:0]                div_cfg,   next_div_cfg;
  logic [31:0]                delay_cfg, next_delay_cfg;
  logic [`DWS_ST_W-1:0]       stat,      next_stat;
  logic [`DWS_ST_W-1:0]       mask,      next_mask;
  dws_pkg::dws_state_t        state,     next_state;
  dws_pkg::dws_sample_t       mem [DEPTH];
  dws_pkg::dws_sample_t       next_mem [DEPTH];
  dws_pkg::dws_sample_t       level,     next_level;
  logic [AW-1:0]              wp,        next_wp;
  logic [AW-1:0]              rp,        next_rp;
  logic [AW-1:0]              rep,       next_rep;
  logic [FW-1:0]              fill,      next_fill;
  logic [31:0]                div_cnt,   next_div_cnt;
  logic [31:0]                del_cnt,   next_del_cnt;
  logic [31:0]                done_cnt,  next_done_cnt;
  logic                       strobe,    next_strobe;
  logic [31:0]                rdq,       next_rdq;
  logic                       irq_q,     next_irq_q;

  // decoded strobes and derived conditions
  logic wr_data, wr_cmd, tb_tick, held, begin_edge;
  assign wr_data    = wr && (addr == `DWS_OFS_DATA);
  assign wr_cmd     = wr && (addr == `DWS_OFS_CMD);
  // internal timebase is the system clock itself; an external one ticks on its rising edge
  assign tb_tick    = ctrl.timebase_ext ? pin_rise[`DWS_PIN_TBASE] : 1'b1;
  assign held       = ctrl.hold_en && (pin_lvl[`DWS_PIN_HOLD] ^ ctrl.hold_low); // R16
  assign begin_edge = ctrl.begin_fall ? pin_fall[`DWS_PIN_BEGIN] : pin_rise[`DWS_PIN_BEGIN]; // R15

  // sequencer, queue and register next-state logic
  always_comb
  begin
    logic                 do_update;
    logic                 is_local;
    logic [`DWS_ST_W-1:0] ev;
    logic [FW-1:0]        fill_tmp;
    do_update      = 1'b0;
    is_local       = (ctrl.timing == `DWS_TIM_CONT) && (ctrl.regen == `DWS_RGN_LOCAL); // R9
    ev             = '0;
    fill_tmp       = fill;
    next_ctrl      = ctrl;
    next_count_cfg = count_cfg;
    next_div_cfg   = div_cfg;
    next_delay_cfg = delay_cfg;
    next_mask      = mask;
    next_state     = state;
    next_mem       = mem;
    next_level     = level;
    next_wp        = wp;
    next_rp        = rp;
    next_rep       = rep;
    next_div_cnt   = div_cnt;
    next_del_cnt   = del_cnt;
    next_done_cnt  = done_cnt;
    next_strobe    = 1'b0;
    if (wr)
    begin
      case (addr)
        `DWS_OFS_CTRL:  next_ctrl      = wdata[`DWS_CTRL_W-1:0];
        `DWS_OFS_COUNT: next_count_cfg = wdata;
        `DWS_OFS_DIV:   next_div_cfg   = wdata;
        `DWS_OFS_DELAY: next_delay_cfg = wdata;
        `DWS_OFS_MASK:  next_mask      = wdata[`DWS_ST_W-1:0];
        default:        ;
      endcase
    end
    // timing engine
    case (state)
      dws_pkg::DWS_IDLE:
      begin
        if (wr_cmd && wdata[`DWS_CMD_UPDATE] && (ctrl.timing == `DWS_TIM_ONDEMAND))
          do_update = 1'b1; // R4
        if (wr_cmd && wdata[`DWS_CMD_START] && (ctrl.timing != `DWS_TIM_ONDEMAND))
        begin
          next_done_cnt = 32'h0;
          next_rep      = '0;
          next_del_cnt  = delay_cfg;
          if (ctrl.begin_en)
            next_state = dws_pkg::DWS_ARMED; // R14
          else
          begin
            next_state = ctrl.pace_ext ? dws_pkg::DWS_RUN : dws_pkg::DWS_DELAY; // R15
            ev[`DWS_ST_BEGUN] = 1'b1;
          end
        end
      end
      dws_pkg::DWS_ARMED:
      begin
        if (begin_edge)
        begin
          next_state = ctrl.pace_ext ? dws_pkg::DWS_RUN : dws_pkg::DWS_DELAY; // R15
          ev[`DWS_ST_BEGUN] = 1'b1;
        end
      end
      dws_pkg::DWS_DELAY:
      begin
        // pause masks timebase ticks, so the delay stretches while held
        if (tb_tick && !held)
        begin
          if (del_cnt <= 32'h1)
          begin
            do_update    = 1'b1; // R17
            next_state   = dws_pkg::DWS_RUN;
            next_div_cnt = div_cfg - 32'h1;
          end
          else
            next_del_cnt = del_cnt - 32'h1;
        end
      end
      dws_pkg::DWS_RUN:
      begin
        if (ctrl.pace_ext)
          do_update = pin_rise[`DWS_PIN_PACE] && !held; // R5 R16
        else if (tb_tick && !held)
        begin
          if (div_cnt == 32'h0)
          begin
            do_update    = 1'b1; // R5
            next_div_cnt = div_cfg - 32'h1;
          end
          else
            next_div_cnt = div_cnt - 32'h1;
        end
      end
      default: next_state = dws_pkg::DWS_IDLE;
    endcase
    // one update refreshes both converters from one queue entry; on an empty queue standard regeneration repeats the last pair in DWS_RUN only
    if (do_update)
    begin
      if (fill == '0)
      begin
        if ((ctrl.timing == `DWS_TIM_CONT) && (ctrl.regen == `DWS_RGN_STD) && (state == dws_pkg::DWS_RUN))
          next_strobe = 1'b1; // R10
        else if (state != dws_pkg::DWS_IDLE)
        begin
          ev[`DWS_ST_UNDER] = 1'b1; // R13
          next_state        = dws_pkg::DWS_IDLE; // R18
        end
      end
      else
      begin
        next_strobe = 1'b1;
        if (is_local && (state != dws_pkg::DWS_IDLE))
        begin
          next_level = mem[rp + rep]; // R11
          next_rep   = ((FW'(rep) + FW'(1'b1)) == fill) ? '0 : rep + AW'(1'b1);
        end
        else
        begin
          next_level = mem[rp]; // R1 R2 R6
          next_rp    = rp + AW'(1'b1);
          fill_tmp   = fill - FW'(1'b1);
        end
        if (state != dws_pkg::DWS_IDLE)
        begin
          next_done_cnt = done_cnt + 32'h1;
          if ((ctrl.timing == `DWS_TIM_FINITE) && ((done_cnt + 32'h1) >= count_cfg))
          begin
            ev[`DWS_ST_DONE] = 1'b1; // R7
            next_state       = dws_pkg::DWS_IDLE;
          end
        end
      end
    end
    // host data enters the queue; refused while replaying locally or when full
    if (wr_data)
    begin
      if ((is_local && (state != dws_pkg::DWS_IDLE)) || (fill == FW'(DEPTH)))
        ev[`DWS_ST_REJECT] = 1'b1; // R11
      else
      begin
        next_mem[wp] = wdata; // R3
        next_wp      = wp + AW'(1'b1);
        fill_tmp     = fill_tmp + FW'(1'b1);
      end
    end
    next_fill = fill_tmp;
    // stop ends any run; continuous mode has no other way out but underflow
    if (wr_cmd && wdata[`DWS_CMD_STOP])
      next_state = dws_pkg::DWS_IDLE; // R8
    if (wr_cmd && wdata[`DWS_CMD_FLUSH] && (state == dws_pkg::DWS_IDLE))
    begin
      next_wp   = '0;
      next_rp   = '0;
      next_fill = '0;
    end
    // sticky status: write one to clear, a new event in the same cycle wins
    next_stat = stat;
    if (wr && (addr == `DWS_OFS_STAT))
      next_stat = stat & ~wdata[`DWS_ST_W-1:0];
    next_stat  = next_stat | ev; // R18
    next_irq_q = |(next_stat & next_mask);
    // read data stands only in the cycle after the strobe
    next_rdq = 32'h0;
    if (rd)
    begin
      case (addr)
        `DWS_OFS_CTRL:  next_rdq = {{(32-`DWS_CTRL_W){1'b0}}, ctrl};
        `DWS_OFS_COUNT: next_rdq = count_cfg;
        `DWS_OFS_DIV:   next_rdq = div_cfg;
        `DWS_OFS_DELAY: next_rdq = delay_cfg;
        `DWS_OFS_STAT:  next_rdq = {{(32-`DWS_ST_W){1'b0}}, stat};
        `DWS_OFS_MASK:  next_rdq = {{(32-`DWS_ST_W){1'b0}}, mask};
        `DWS_OFS_STATE: next_rdq = {30'h0, state};
        `DWS_OFS_LEVEL: next_rdq = level;
        `DWS_OFS_FILL:  next_rdq = {{(32-FW){1'b0}}, fill};
        `DWS_OFS_DONE:  next_rdq = done_cnt;
        default:        next_rdq = 32'h0;
      endcase
    end
  end
  // registers only
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      ctrl      <= `DWS_CTRL_RST;
      count_cfg <= `DWS_COUNT_RST;
      div_cfg   <= `DWS_DIV_RST;
      delay_cfg <= `DWS_DELAY_RST;
      stat      <= '0;
      mask      <= '0;
      state     <= dws_pkg::DWS_IDLE;
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= '0;
      level     <= '0;
      wp        <= '0;
      rp        <= '0;
      rep       <= '0;
      fill      <= '0;
      div_cnt   <= 32'h0;
      del_cnt   <= 32'h0;
      done_cnt  <= 32'h0;
      strobe    <= 1'b0;
      rdq       <= 32'h0;
      irq_q     <= 1'b0;
      running   <= 1'b0;
    end
    else
    begin
      ctrl      <= next_ctrl;
      count_cfg <= next_count_cfg;
      div_cfg   <= next_div_cfg;
      delay_cfg <= next_delay_cfg;
      stat      <= next_stat;
      mask      <= next_mask;
      state     <= next_state;
      mem       <= next_mem;
      level     <= next_level;
      wp        <= next_wp;
      rp        <= next_rp;
      rep       <= next_rep;
      fill      <= next_fill;
      div_cnt   <= next_div_cnt;
      del_cnt   <= next_del_cnt;
      done_cnt  <= next_done_cnt;
      strobe    <= next_strobe;
      rdq       <= next_rdq;
      irq_q     <= next_irq_q;
      running   <= (next_state != dws_pkg::DWS_IDLE);
    end
  end
  // outputs straight from flip-flops; converters hold the last value after a halt
  assign converter_ch0 = level.ch0; // R1
  assign converter_ch1 = level.ch1; // R1
  assign update_strobe = strobe;
  assign rdata         = rdq;
  assign irq           = irq_q;

endmodule : dws_sequencer

// [tb/dws_seq_monitor.sv]
// port checker for the waveform sequencer
`timescale 1ns/1ps
`include "dws_regs.svh"

module dws_monitor #(
  parameter int DEPTH = 16
) (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        update_pace_clock,
  input wire logic        update_pace_timebase,
  input wire logic        generation_begin_trigger,
  input wire logic        generation_hold_trigger,
  input wire logic [15:0] converter_ch0,
  input wire logic [15:0] converter_ch1,
  input wire logic        update_strobe,
  input wire logic        running,
  input wire logic        irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // update command seen on the bus, kept as a plain net for $past
  logic s_cmd_upd;
  assign s_cmd_upd = wr && addr == `DWS_OFS_CMD && wdata[`DWS_CMD_UPDATE];

  // a command write carrying one cmd bit
  sequence s_cmd(int b);
    wr && addr == `DWS_OFS_CMD && wdata[b];
  endsequence
  // host issues no write for two cycles
  sequence s_quiet2;
    (!wr) [*2];
  endsequence

  AST_PACE_PAIR: assert property (!update_strobe && $past(nrst) |-> $stable({converter_ch1, converter_ch0}))
    else $error("converter moved without update");
  // the last update of a run lands in the cycle running drops, so only a settled idle counts
  AST_SOFT_ONE: assert property (update_strobe && !running && !$past(running) |-> $past(s_cmd_upd))
    else $error("idle update without command");
  AST_STOP_IDLE: assert property (s_cmd(`DWS_CMD_STOP) |-> ##[1:2] !running)
    else $error("stop did not end run");
  AST_STOP_QUIET: assert property (s_cmd(`DWS_CMD_STOP) ##1 s_quiet2 |=> !update_strobe)
    else $error("update after stop");
  AST_FINITE_END: assert property ($fell(running) |=> !update_strobe)
    else $error("update after run ended");
  AST_IRQ_MASK: assert property (wr && addr == `DWS_OFS_MASK && wdata[3:0] == 4'h0 |=> !irq)
    else $error("irq with all masked");
  AST_LEVEL_PAIR: assert property (rd && addr == `DWS_OFS_LEVEL |=> update_strobe
                                   || rdata == {converter_ch1, converter_ch0})
    else $error("level differs from converters");
  AST_RD_ONLY: assert property (rdata != 32'h0 |-> $past(rd))
    else $error("read data without read");
endmodule : dws_monitor

bind dws_sequencer dws_monitor #(.DEPTH(DEPTH)) mon (
  .sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .update_pace_clock(update_pace_clock), .update_pace_timebase(update_pace_timebase),
  .generation_begin_trigger(generation_begin_trigger), .generation_hold_trigger(generation_hold_trigger),
  .converter_ch0(converter_ch0), .converter_ch1(converter_ch1), .update_strobe(update_strobe),
  .running(running), .irq(irq)
);

// [tb/dws_host_model.sv]
// host side model: register port master
`timescale 1ns/1ps

module dws_host_model (
  input  wire logic        sys_clk,
  input  wire logic [31:0] rdata,
  output logic      [7:0]  addr,
  output logic      [31:0] wdata,
  output logic             wr,
  output logic             rd
);
  // bus idle at time zero
  initial
  begin
    addr  = 8'h00;
    wdata = 32'h0;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // one write; released lines turn over so stale values never match
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask : put

  // one read; data stands only in the cycle after the strobe
  task automatic get(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    addr <= ~a;
    #1 d = rdata;
  endtask : get
endmodule : dws_host_model

// [tb/dws_testbench.sv]
// self-checking bench for the waveform sequencer
`timescale 1ns/1ps
`include "dws_regs.svh"

module testbench;
  logic        sys_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic        pace    = 1'b0;
  logic        tbase   = 1'b0;
  logic        trig    = 1'b0;
  logic        hold    = 1'b0;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wr;
  logic        rd;
  logic [15:0] ch0;
  logic [15:0] ch1;
  logic        stb;
  logic        running;
  logic        irq;
  logic [31:0] v;
  int          mismatches = 0;
  int          cmp_count  = 0;

  always #25 sys_clk = ~sys_clk;

  dws_host_model host (.sys_clk(sys_clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

  dws_sequencer #(.DEPTH(16)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .update_pace_clock(pace), .update_pace_timebase(tbase), .generation_begin_trigger(trig),
    .generation_hold_trigger(hold), .converter_ch0(ch0), .converter_ch1(ch1),
    .update_strobe(stb), .running(running), .irq(irq)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    host.get(a, v);
    chk(v, exp);
  endtask : rchk

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  // bounded wait for the run to end; a hang closes the run
  task automatic idle_wait;
    int i;
    repeat (2) @(posedge sys_clk);
    #1;
    for (i = 0; i < 400 && running !== 1'b0; i++)
    begin
      @(posedge sys_clk);
      #1;
    end
    if (running !== 1'b0)
    begin
      mismatches++;
      close_out();
    end
  endtask : idle_wait

  task automatic t_reset;
    rchk(`DWS_OFS_CTRL, 32'h0);
    rchk(`DWS_OFS_COUNT, `DWS_COUNT_RST);
    rchk(`DWS_OFS_DELAY, `DWS_DELAY_RST);
    host.put(8'h30, 32'hffff_ffff);
    rchk(8'h30, 32'h0);
    rchk(`DWS_OFS_STAT, 32'h0);
    $display("test reset done");
  endtask : t_reset

  // one command per conversion, the host never batches them
  task automatic t_ondemand;
    host.put(`DWS_OFS_DATA, 32'h2222_1111);
    host.put(`DWS_OFS_DATA, 32'h4444_3333);
    rchk(`DWS_OFS_FILL, 32'h2);
    host.put(`DWS_OFS_CMD, 32'h4);
    rchk(`DWS_OFS_FILL, 32'h1);
    chk({ch1, ch0}, 32'h2222_1111);
    host.put(`DWS_OFS_CMD, 32'h4);
    host.put(`DWS_OFS_CMD, 32'h4);
    rchk(`DWS_OFS_LEVEL, 32'h4444_3333);
    $display("test on-demand done");
  endtask : t_ondemand

  task automatic t_finite;
    int n;
    host.put(`DWS_OFS_COUNT, 32'h3);
    host.put(`DWS_OFS_DIV, 32'h2);
    host.put(`DWS_OFS_MASK, 32'hf);
    for (n = 1; n <= 3; n++)
      host.put(`DWS_OFS_DATA, 32'h0100_0010 * n);
    host.put(`DWS_OFS_CTRL, 32'h1);
    host.put(`DWS_OFS_CMD, 32'h1);
    n = 0;
    while (stb !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk(n, `DWS_DELAY_RST);
    idle_wait();
    rchk(`DWS_OFS_DONE, 32'h3);
    rchk(`DWS_OFS_STAT, 32'h9);
    chk(irq, 1'b1);
    chk(ch0, 16'h0030);
    rchk(`DWS_OFS_FILL, 32'h0);
    host.put(`DWS_OFS_STAT, 32'hf);
    rchk(`DWS_OFS_STAT, 32'h0);
    chk(irq, 1'b0);
    host.put(`DWS_OFS_MASK, 32'h0);
    $display("test finite done");
  endtask : t_finite

  task automatic t_under;
    host.put(`DWS_OFS_DATA, 32'h5555_6666);
    host.put(`DWS_OFS_CTRL, 32'ha);
    host.put(`DWS_OFS_CMD, 32'h1);
    idle_wait();
    rchk(`DWS_OFS_STAT, 32'ha);
    rchk(`DWS_OFS_DONE, 32'h1);
    chk({ch1, ch0}, 32'h5555_6666);
    host.put(`DWS_OFS_STAT, 32'hf);
    $display("test underflow done");
  endtask : t_under

  // two entries only, well inside the queue depth
  task automatic t_local;
    host.put(`DWS_OFS_CTRL, 32'h6);
    host.put(`DWS_OFS_DATA, 32'h0002_0001);
    host.put(`DWS_OFS_DATA, 32'h0004_0003);
    host.put(`DWS_OFS_CMD, 32'h1);
    host.put(`DWS_OFS_DATA, 32'h0009_0009);
    rchk(`DWS_OFS_STAT, 32'hc);
    repeat (20) @(posedge sys_clk);
    #1;
    chk(running, 1'b1);
    rchk(`DWS_OFS_FILL, 32'h2);
    host.put(`DWS_OFS_CMD, 32'h3);
    idle_wait();
    host.put(`DWS_OFS_CMD, 32'h8);
    rchk(`DWS_OFS_FILL, 32'h0);
    host.put(`DWS_OFS_STAT, 32'hf);
    $display("test local replay done");
  endtask : t_local

  task automatic t_hold;
    @(posedge sys_clk);
    hold <= 1'b1;
    host.put(`DWS_OFS_COUNT, 32'h2);
    host.put(`DWS_OFS_DATA, 32'h0001_0001);
    host.put(`DWS_OFS_DATA, 32'h0002_0002);
    host.put(`DWS_OFS_CTRL, 32'h81);
    host.put(`DWS_OFS_CMD, 32'h1);
    repeat (40) @(posedge sys_clk);
    rchk(`DWS_OFS_DONE, 32'h0);
    @(posedge sys_clk);
    hold <= 1'b0;
    idle_wait();
    rchk(`DWS_OFS_DONE, 32'h2);
    rchk(`DWS_OFS_STAT, 32'h9);
    $display("test pause done");
  endtask : t_hold

  // start command arms the run, falling start edge begins it, then each external pace rise gives one update
  task automatic t_trig;
    int n;
    @(posedge sys_clk);
    trig <= 1'b1;
    host.put(`DWS_OFS_COUNT, 32'h2);
    host.put(`DWS_OFS_DATA, 32'h0007_0006);
    host.put(`DWS_OFS_DATA, 32'h0009_0008);
    host.put(`DWS_OFS_CTRL, 32'h71);
    host.put(`DWS_OFS_CMD, 32'h1);
    repeat (8) @(posedge sys_clk);
    rchk(`DWS_OFS_STATE, 32'h1);
    @(posedge sys_clk);
    trig <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rchk(`DWS_OFS_STATE, 32'h3);
    rchk(`DWS_OFS_DONE, 32'h0);
    for (n = 0; n < 2; n++)
    begin
      @(posedge sys_clk);
      pace <= 1'b1;
      repeat (6) @(posedge sys_clk);
      pace <= 1'b0;
      repeat (6) @(posedge sys_clk);
      #1;
      chk({ch1, ch0}, (n == 0) ? 32'h0007_0006 : 32'h0009_0008);
    end
    idle_wait();
    rchk(`DWS_OFS_DONE, 32'h2);
    rchk(`DWS_OFS_STAT, 32'h9);
    host.put(`DWS_OFS_STAT, 32'hf);
    $display("test trigger done");
  endtask : t_trig

  // reset, then every scenario in turn
  initial
  begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_ondemand();
    t_finite();
    t_under();
    t_local();
    t_hold();
    t_trig();
    close_out();
  end
endmodule : testbench
